// ==== swr_rom_layer.sv ====
// transaction layer: rom commands, identity, search and scratchpad writes
`timescale 1ns/1ps
`default_nettype none
module swr_rom_layer #(
  // arbitrary identity values, replace per product
  parameter logic [7:0]  FAMILY_CODE = 8'h5a,
  parameter logic [47:0] SERIAL      = 48'h0123_4567_89ab,
  parameter int unsigned RST_CYC     = swr_pkg::RST_LOW_CYC,
  parameter int unsigned PRES_CYC    = swr_pkg::PRES_LEN_CYC,
  // bit timing may be scaled down, but a zero slot must stay under RST_CYC
  parameter int unsigned SMP_CYC     = swr_pkg::SAMPLE_CYC,
  parameter int unsigned HOLD_CYC    = swr_pkg::TX_HOLD_CYC,
  parameter int unsigned PWAIT_CYC   = swr_pkg::PRES_WAIT_CYC
) (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic dq_in,
  output logic      dq_out,
  output logic      dq_oe_n,
  output logic      sp_wr,
  output logic [2:0] sp_page,
  output logic [2:0] sp_addr,
  output logic [7:0] sp_data
);
  import swr_pkg::*;

  // identity sent lsb first: family, serial, crc
  localparam logic [63:0] IDENT =
    {swr_crc8({SERIAL, FAMILY_CODE}), SERIAL, FAMILY_CODE};

  typedef struct packed {
    swr_state_t state;
    logic [7:0] sr;
    logic [5:0] bitcnt;
    logic [1:0] phase;
    logic       miss;
    logic [2:0] page;
    logic [2:0] idx;
    logic       wr;
    logic [2:0] waddr;
    logic [7:0] wdata;
  } swr_rom_q_t;

  swr_rom_q_t q;
  swr_rom_q_t next_q;
  logic       id_bit;
  logic [7:0] byte_v;
  logic       byte_end;

  swr_slot_if lnk ();

  swr_slot #(
    .RST_CYC  (RST_CYC),
    .PRES_CYC (PRES_CYC),
    .SMP_CYC  (SMP_CYC),
    .HOLD_CYC (HOLD_CYC),
    .PWAIT_CYC(PWAIT_CYC)
  ) u_slot (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .dq_in    (dq_in),
    .dq_out   (dq_out),
    .dq_oe_n  (dq_oe_n),
    .lnk      (lnk)
  );

  // current identity bit and the byte being shifted in
  assign id_bit   = IDENT[q.bitcnt];
  assign byte_v   = {lnk.rx_bit, q.sr[7:1]};
  assign byte_end = (q.bitcnt[2:0] == BYTE_LAST);

  assign lnk.tx_mode = (q.state == ST_READID) ||
                       (q.state == ST_SEARCH && q.phase != 2'd2);
  assign lnk.tx_bit  = (q.phase == 2'd1) ? ~id_bit : id_bit;

  // next state of the transaction layer
  always_comb begin
    next_q    = q;
    next_q.wr = 1'b0;
    if (lnk.bus_rst) begin
      next_q.state  = ST_ROMCMD;
      next_q.bitcnt = '0;
      next_q.phase  = '0;
      next_q.miss   = 1'b0;
      next_q.idx    = '0;
    end else if (lnk.bit_done) begin
      next_q.sr     = byte_v;
      next_q.bitcnt = q.bitcnt + 1'b1;
      case (q.state)
        ST_ROMCMD: begin
          if (byte_end) begin
            next_q.bitcnt = '0;
            next_q.miss   = 1'b0;
            next_q.phase  = '0;
            case (byte_v)
              CMD_READ_ID:  next_q.state = ST_READID;
              CMD_MATCH_ID: next_q.state = ST_MATCH;
              CMD_SKIP_ID:  next_q.state = ST_MEMCMD;
              CMD_SEARCH:   next_q.state = ST_SEARCH;
              default:      next_q.state = ST_IDLE;
            endcase
          end
        end
        ST_READID: begin
          if (q.bitcnt == ID_LAST) begin
            next_q.state  = ST_MEMCMD;
            next_q.bitcnt = '0;
          end
        end
        ST_MATCH: begin
          next_q.miss = q.miss | (lnk.rx_bit != id_bit);
          if (q.bitcnt == ID_LAST) begin
            next_q.bitcnt = '0;
            next_q.state  = next_q.miss ? ST_IDLE : ST_MEMCMD;
          end
        end
        ST_SEARCH: begin
          next_q.bitcnt = q.bitcnt;
          next_q.phase  = q.phase + 1'b1;
          if (q.phase == 2'd2) begin
            next_q.phase = '0;
            if (lnk.rx_bit != id_bit) begin
              next_q.state = ST_IDLE;
            end else if (q.bitcnt == ID_LAST) begin
              next_q.state  = ST_MEMCMD;
              next_q.bitcnt = '0;
            end else begin
              next_q.bitcnt = q.bitcnt + 1'b1;
            end
          end
        end
        ST_MEMCMD: begin
          if (byte_end) begin
            next_q.bitcnt = '0;
            next_q.state  = (byte_v == CMD_WRITE_SP) ? ST_PAGE : ST_IDLE;
          end
        end
        ST_PAGE: begin
          if (byte_end) begin
            next_q.bitcnt = '0;
            next_q.idx    = '0;
            next_q.page   = byte_v[2:0];
            next_q.state  = (byte_v <= PAGE_MAX) ? ST_WRDATA : ST_IDLE;
          end
        end
        ST_WRDATA: begin
          if (byte_end) begin
            next_q.wr    = 1'b1;
            next_q.waddr = q.idx;
            next_q.wdata = byte_v;
            next_q.idx   = q.idx + 1'b1;
            // bytes past the page end are ignored
            if (q.idx == BYTE_LAST) begin
              next_q.state = ST_IDLE;
            end
          end
        end
        default: begin
          next_q.bitcnt = '0;
        end
      endcase
    end
  end

  // state register, waits for a bus reset after power up
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      q       <= '0;
      q.state <= ST_IDLE;
    end else begin
      q <= next_q;
    end
  end

  assign sp_wr   = q.wr;
  assign sp_page = q.page;
  assign sp_addr = q.waddr;
  assign sp_data = q.wdata;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  property p_slave_only;
    lnk.tx_mode |-> q.state == ST_READID || q.state == ST_SEARCH;
  endproperty
  a_slave_only: assert property (p_slave_only)
    else $error("device transmits outside an identity phase");

  property p_reset_abort;
    lnk.bus_rst |=> q.state == ST_ROMCMD && q.bitcnt == 6'd0;
  endproperty
  a_reset_abort: assert property (p_reset_abort)
    else $error("bus reset did not restart the transaction");

  property p_read_cmd;
    q.state == ST_ROMCMD && lnk.bit_done && !lnk.bus_rst && byte_end &&
      byte_v == CMD_READ_ID |=> q.state == ST_READID;
  endproperty
  a_read_cmd: assert property (p_read_cmd)
    else $error("read identity command not decoded");

  property p_id_order;
    q.state == ST_READID && lnk.bit_done && !lnk.bus_rst &&
      q.bitcnt != ID_LAST |=> q.bitcnt == $past(q.bitcnt) + 6'd1;
  endproperty
  a_id_order: assert property (p_id_order)
    else $error("identity bit order broken");

  property p_match_fail;
    q.state == ST_MATCH && lnk.bit_done && !lnk.bus_rst &&
      q.bitcnt == ID_LAST && (q.miss || lnk.rx_bit != id_bit)
      |=> q.state == ST_IDLE;
  endproperty
  a_match_fail: assert property (p_match_fail)
    else $error("mismatched identity was accepted");

  property p_skip;
    q.state == ST_ROMCMD && lnk.bit_done && !lnk.bus_rst && byte_end &&
      byte_v == CMD_SKIP_ID |=> q.state == ST_MEMCMD;
  endproperty
  a_skip: assert property (p_skip)
    else $error("skip command did not reach memory decoding");

  property p_search_drop;
    q.state == ST_SEARCH && q.phase == 2'd2 && lnk.bit_done &&
      !lnk.bus_rst && lnk.rx_bit != id_bit |=> q.state == ST_IDLE;
  endproperty
  a_search_drop: assert property (p_search_drop)
    else $error("search kept a deselected device");

  property p_sp_write;
    q.state == ST_WRDATA && lnk.bit_done && !lnk.bus_rst && byte_end
      |=> sp_wr && sp_addr == $past(q.idx) && sp_data == $past(byte_v);
  endproperty
  a_sp_write: assert property (p_sp_write)
    else $error("scratchpad byte not written");

  property p_bad_page;
    q.state == ST_PAGE && lnk.bit_done && !lnk.bus_rst && byte_end &&
      byte_v > PAGE_MAX |=> q.state == ST_IDLE ##1 !sp_wr;
  endproperty
  a_bad_page: assert property (p_bad_page)
    else $error("page above range accepted");

endmodule : swr_rom_layer
`default_nettype wire

// ==== swr_pkg.sv ====
// shared constants, types and helpers of the single wire slave rom layer
// Operation
// - one master starts all traffic; this device only answers as a slave.
// - line driven open drain only; zero pulls low, one releases, wired-AND.
// - line held low too long is a bus reset; abandon any transaction.
// - order is reset, one rom command, one memory command, then data.
// - master reset pulse is answered by a presence pulse from the device.
// - rom command is one byte, decoded before any memory command.
// - read identity 33h sends family, 48-bit serial, then crc.
// - match 55h plus 64 bits; mismatch means silence until next reset.
// - skip cch goes straight to memory command decoding.
// - search f0h sends bit, complement, then reads the master's bit.
// - search bit from master differing from own bit drops device until reset.
// - identity bits go least significant bit first.
// - write scratchpad 4eh, page 00h-07h, bytes stored from byte 0.
// - reset ends a scratchpad write; bytes already taken are kept.
package swr_pkg;

  // clock and bus timing, times in microseconds
  localparam int unsigned CLK_MHZ       = 50;
  localparam int unsigned RST_LOW_US    = 480;
  localparam int unsigned RST_LOW_CYC   = RST_LOW_US * CLK_MHZ;
  localparam int unsigned PRES_WAIT_US  = 30;
  localparam int unsigned PRES_WAIT_CYC = PRES_WAIT_US * CLK_MHZ;
  localparam int unsigned PRES_LEN_US   = 120;
  localparam int unsigned PRES_LEN_CYC  = PRES_LEN_US * CLK_MHZ;
  localparam int unsigned SAMPLE_US     = 30;
  localparam int unsigned SAMPLE_CYC    = SAMPLE_US * CLK_MHZ;
  localparam int unsigned TX_HOLD_US    = 30;
  localparam int unsigned TX_HOLD_CYC   = TX_HOLD_US * CLK_MHZ;
  localparam int unsigned CNT_W         = 16;

  // command bytes and limits
  localparam logic [7:0] CMD_READ_ID  = 8'h33;
  localparam logic [7:0] CMD_MATCH_ID = 8'h55;
  localparam logic [7:0] CMD_SKIP_ID  = 8'hcc;
  localparam logic [7:0] CMD_SEARCH   = 8'hf0;
  localparam logic [7:0] CMD_WRITE_SP = 8'h4e;
  localparam logic [7:0] PAGE_MAX     = 8'h07;
  localparam logic [5:0] ID_LAST      = 6'h3f;
  localparam logic [2:0] BYTE_LAST    = 3'h7;
  localparam logic [7:0] CRC_POLY     = 8'h8c;

  // slot engine states
  typedef enum logic [3:0] {
    SL_IDLE  = 4'h1,
    SL_LOW   = 4'h2,
    SL_PWAIT = 4'h4,
    SL_PDRV  = 4'h8
  } swr_slot_st_t;

  // transaction states
  typedef enum logic [7:0] {
    ST_IDLE   = 8'h01,
    ST_ROMCMD = 8'h02,
    ST_READID = 8'h04,
    ST_MATCH  = 8'h08,
    ST_SEARCH = 8'h10,
    ST_MEMCMD = 8'h20,
    ST_PAGE   = 8'h40,
    ST_WRDATA = 8'h80
  } swr_state_t;

  // identity crc over family code and serial, lsb first
  function automatic logic [7:0] swr_crc8(input logic [55:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 56; i++) begin
      if (c[0] ^ d[i]) begin
        c = (c >> 1) ^ CRC_POLY;
      end else begin
        c = c >> 1;
      end
    end
    return c;
  endfunction : swr_crc8

endpackage : swr_pkg

// ==== swr_slot_if.sv ====
// bit level link between the slot engine and the transaction logic
`timescale 1ns/1ps
`default_nettype none
interface swr_slot_if;
  logic bus_rst;
  logic bit_done;
  logic rx_bit;
  logic tx_mode;
  logic tx_bit;

  modport slot (output bus_rst, output bit_done, output rx_bit,
                input tx_mode, input tx_bit);
  modport rom  (input bus_rst, input bit_done, input rx_bit,
                output tx_mode, output tx_bit);
endinterface : swr_slot_if
`default_nettype wire

// ==== swr_slot.sv ====
// slot engine: line sync, reset detection, presence and bit slots
`timescale 1ns/1ps
`default_nettype none
module swr_slot #(
  parameter int unsigned RST_CYC   = swr_pkg::RST_LOW_CYC,
  parameter int unsigned PRES_CYC  = swr_pkg::PRES_LEN_CYC,
  parameter int unsigned SMP_CYC   = swr_pkg::SAMPLE_CYC,
  parameter int unsigned HOLD_CYC  = swr_pkg::TX_HOLD_CYC,
  parameter int unsigned PWAIT_CYC = swr_pkg::PRES_WAIT_CYC
) (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic dq_in,
  output logic      dq_out,
  output logic      dq_oe_n,
  swr_slot_if.slot  lnk
);
  import swr_pkg::*;

  typedef struct packed {
    swr_slot_st_t     st;
    logic [CNT_W-1:0] cnt;
    logic             s1;
    logic             s2;
    logic             s3;
    logic             line;
    logic             oe_n;
    logic             lvl;
    logic             rst_p;
    logic             done;
    logic             rx;
  } swr_slot_q_t;

  swr_slot_q_t q;
  swr_slot_q_t next_q;

  // next state of the slot engine
  always_comb begin
    next_q       = q;
    next_q.s1    = dq_in;
    next_q.s2    = q.s1;
    next_q.s3    = q.s2;
    next_q.rst_p = 1'b0;
    next_q.done  = 1'b0;
    next_q.lvl   = 1'b0;
    // a level counts only once the last two stages agree
    if (q.s2 == q.s3) begin
      next_q.line = q.s3;
    end
    if (q.cnt != {CNT_W{1'b1}}) begin
      next_q.cnt = q.cnt + 1'b1;
    end
    case (q.st)
      SL_IDLE: begin
        if (q.line && !next_q.line) begin
          next_q.st  = SL_LOW;
          next_q.cnt = '0;
          if (lnk.tx_mode && !lnk.tx_bit) begin
            next_q.oe_n = 1'b0;
          end
        end
      end
      SL_LOW: begin
        if (q.cnt == CNT_W'(HOLD_CYC)) begin
          next_q.oe_n = 1'b1;
        end
        if (q.cnt == CNT_W'(SMP_CYC)) begin
          next_q.done = 1'b1;
          next_q.rx   = q.line;
        end
        if (!q.line && q.cnt >= CNT_W'(RST_CYC)) begin
          next_q.rst_p = 1'b1;
          next_q.oe_n  = 1'b1;
          next_q.st    = SL_PWAIT;
        end else if (q.line && q.cnt > CNT_W'(SMP_CYC)) begin
          next_q.st = SL_IDLE;
        end
      end
      SL_PWAIT: begin
        // presence delay runs from the rising edge only
        if (!q.line) begin
          next_q.cnt = '0;
        end else if (q.cnt == CNT_W'(PWAIT_CYC)) begin
          next_q.st   = SL_PDRV;
          next_q.cnt  = '0;
          next_q.oe_n = 1'b0;
        end
      end
      SL_PDRV: begin
        if (q.cnt == CNT_W'(PRES_CYC)) begin
          next_q.st   = SL_IDLE;
          next_q.oe_n = 1'b1;
        end
      end
      default: begin
        next_q.st   = SL_IDLE;
        next_q.oe_n = 1'b1;
      end
    endcase
  end

  // state register, line assumed released at reset
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      q      <= '0;
      q.st   <= SL_IDLE;
      q.s1   <= 1'b1;
      q.s2   <= 1'b1;
      q.s3   <= 1'b1;
      q.line <= 1'b1;
      q.oe_n <= 1'b1;
      q.rx   <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  assign dq_out       = q.lvl;
  assign dq_oe_n      = q.oe_n;
  assign lnk.bus_rst  = q.rst_p;
  assign lnk.bit_done = q.done;
  assign lnk.rx_bit   = q.rx;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  property p_open_drain;
    dq_out == 1'b0;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("data pin drives a high level");

  property p_long_low;
    lnk.bus_rst |-> $past(q.cnt) >= CNT_W'(RST_CYC) && $past(q.line) == 1'b0;
  endproperty
  a_long_low: assert property (p_long_low)
    else $error("bus reset without a long low");

  property p_presence;
    q.st == SL_PDRV |-> !dq_oe_n;
  endproperty
  a_presence: assert property (p_presence)
    else $error("presence pulse not driven");

endmodule : swr_slot
`default_nettype wire

// ==== swr_master.sv ====
// bus master model that drives the single wire through an open-drain pull-down
`timescale 1ns/1ps
`default_nettype none
module swr_master #(
  parameter int unsigned RST_CYC   = 200,
  parameter int unsigned SMP_CYC   = 60,
  parameter int unsigned PWAIT_CYC = 30,
  parameter int unsigned SLOT_CYC  = 100
) (
  input  wire logic core_clk,
  input  wire logic line,
  output var logic  pull_low
);
  initial pull_low = 1'b0;

  // reset pulse, then count the low cycles of the answer
  task automatic bus_reset(output int unsigned low_cyc);
    low_cyc = 0;
    @(negedge core_clk) pull_low = 1'b1;
    repeat (RST_CYC + 20) @(negedge core_clk);
    pull_low = 1'b0;
    // window covers the fixed wait plus the whole pulse
    repeat (PWAIT_CYC + 400) begin
      @(negedge core_clk);
      if (line === 1'b0) low_cyc++;
    end
  endtask : bus_reset

  // master opens every slot, then leaves the line high
  task automatic slot(input int unsigned low_len, output logic rb);
    rb = 1'b1;
    @(negedge core_clk) pull_low = 1'b1;
    // slot is long enough for the device hold to end before the next fall
    for (int i = 1; i < SLOT_CYC; i++) begin
      @(negedge core_clk);
      if (i == low_len) pull_low = 1'b0;
      if (i == SMP_CYC / 3) rb = line;
    end
  endtask : slot

  task automatic wr_bit(input logic b);
    logic unused;
    // a zero is held past the device sample point
    slot(b ? 5 : SMP_CYC + 15, unused);
  endtask : wr_bit

  task automatic rd_bit(output logic b);
    slot(2, b);
  endtask : rd_bit

  task automatic wr_byte(input logic [7:0] d);
    for (int i = 0; i < 8; i++)
      wr_bit(d[i]);
  endtask : wr_byte

  task automatic rd_byte(output logic [7:0] d);
    for (int i = 0; i < 8; i++)
      rd_bit(d[i]);
  endtask : rd_byte
endmodule : swr_master
`default_nettype wire

// ==== tb_single_wire_slave_rom_layer.sv ====
// self-checking bench for the single wire rom layer
`timescale 1ns/1ps
`default_nettype none
module tb_single_wire_slave_rom_layer;
  import swr_pkg::*;
  localparam int unsigned RST_SIM  = 200;
  localparam int unsigned PRES_SIM = 100;
  // short bit slots keep the run small; a zero write stays under RST_SIM
  localparam int unsigned SMP_SIM   = 60;
  localparam int unsigned PWAIT_SIM = 30;
  // arbitrary identity values for this bench
  localparam logic [7:0]  FAM = 8'h5a;
  localparam logic [47:0] SER = 48'h0123_4567_89ab;

  logic        core_clk;
  logic        rst_n;
  logic        line;
  logic        mst_low;
  logic        dq_out;
  logic        dq_oe_n;
  logic        sp_wr;
  logic [2:0]  sp_page;
  logic [2:0]  sp_addr;
  logic [7:0]  sp_data;
  logic [13:0] wr_log[$];
  int          err_total;
  int          compares;
  int unsigned pres_n;

  // wired-AND with pull-up: low when any party pulls
  assign line = (mst_low || (!dq_oe_n && !dq_out)) ? 1'b0 : 1'b1;

  initial core_clk = 1'b0;
  always #10 core_clk = ~core_clk;

  swr_rom_layer #(.FAMILY_CODE(FAM), .SERIAL(SER), .RST_CYC(RST_SIM),
                  .PRES_CYC(PRES_SIM), .SMP_CYC(SMP_SIM),
                  .HOLD_CYC(SMP_SIM), .PWAIT_CYC(PWAIT_SIM)) u_dut (
    .core_clk(core_clk), .rst_n(rst_n), .dq_in(line), .dq_out(dq_out),
    .dq_oe_n(dq_oe_n), .sp_wr(sp_wr), .sp_page(sp_page),
    .sp_addr(sp_addr), .sp_data(sp_data));

  swr_master #(.RST_CYC(RST_SIM), .SMP_CYC(SMP_SIM),
               .PWAIT_CYC(PWAIT_SIM)) u_mst (
    .core_clk(core_clk), .line(line), .pull_low(mst_low));

  // log every scratchpad store as page, index, data
  always @(posedge core_clk) begin
    if (sp_wr === 1'b1) wr_log.push_back({sp_page, sp_addr, sp_data});
  end

  task automatic chk(input string what, input logic [63:0] exp,
                     input logic [63:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // reference identity crc: reflected polynomial, zero start, lsb first
  function automatic logic [7:0] crc_ref(input logic [55:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 56; i++)
      c = (c[0] ^ d[i]) ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    return c;
  endfunction : crc_ref

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop

  // skip, write the last page, then cut a byte short with a reset
  task automatic t_write_sp();
    wr_log.delete();
    u_mst.bus_reset(pres_n);
    chk("presence_len", PRES_SIM + 1, pres_n);
    u_mst.wr_byte(CMD_SKIP_ID);
    u_mst.wr_byte(CMD_WRITE_SP);
    u_mst.wr_byte(8'h07);
    u_mst.wr_byte(8'ha5);
    u_mst.wr_byte(8'h3c);
    chk("sp_page", 3'h7, sp_page);
    chk("wr_count", 2, wr_log.size());
    chk("wr_first", {3'h7, 3'h0, 8'ha5}, wr_log[0]);
    chk("wr_second", {3'h7, 3'h1, 8'h3c}, wr_log[1]);
    // half a byte, then the line held low: nothing more is stored
    for (int i = 0; i < 4; i++)
      u_mst.wr_bit(1'b0);
    u_mst.bus_reset(pres_n);
    chk("wr_after_abort", 2, wr_log.size());
    chk("presence_again", PRES_SIM + 1, pres_n);
    $display("t_write_sp done");
  endtask : t_write_sp

  // lone device on the bus, so reading the identity is safe
  task automatic t_read_id();
    logic [7:0] b;
    u_mst.bus_reset(pres_n);
    u_mst.wr_byte(CMD_READ_ID);
    u_mst.rd_byte(b);
    chk("family", FAM, b);
    u_mst.rd_byte(b);
    chk("serial_lo", SER[7:0], b);
    $display("t_read_id done");
  endtask : t_read_id

  // keep the device on bit 0, knock it off on bit 1, then hear nobody
  task automatic t_search();
    logic a;
    logic c;
    u_mst.bus_reset(pres_n);
    u_mst.wr_byte(CMD_SEARCH);
    for (int i = 0; i < 3; i++) begin
      u_mst.rd_bit(a);
      u_mst.rd_bit(c);
      chk("search_pair", (i < 2) ? {FAM[i], ~FAM[i]} : 2'b11, {a, c});
      u_mst.wr_bit((i == 1) ? ~FAM[i] : FAM[i]);
    end
    $display("t_search done");
  endtask : t_search

  // a memory command where the rom byte belongs leaves the device silent
  task automatic t_bad_order();
    logic        a;
    logic        c;
    int unsigned n;
    u_mst.bus_reset(pres_n);
    u_mst.wr_byte(CMD_WRITE_SP);
    u_mst.rd_bit(a);
    u_mst.rd_bit(c);
    chk("silent_after_bad_cmd", 2'b11, {a, c});
    // a page above 07h is refused and the data after it dropped
    n = wr_log.size();
    u_mst.bus_reset(pres_n);
    u_mst.wr_byte(CMD_SKIP_ID);
    u_mst.wr_byte(CMD_WRITE_SP);
    u_mst.wr_byte(8'h08);
    u_mst.wr_byte(8'h11);
    chk("bad_page_writes", n, wr_log.size());
    $display("t_bad_order done");
  endtask : t_bad_order

  // true identity selects the device, one flipped bit deselects it
  task automatic t_match();
    logic [63:0] id;
    int unsigned n;
    id = {crc_ref({SER, FAM}), SER, FAM};
    for (int k = 0; k < 2; k++) begin
      n = wr_log.size();
      u_mst.bus_reset(pres_n);
      u_mst.wr_byte(CMD_MATCH_ID);
      for (int i = 0; i < 64; i++)
        u_mst.wr_bit(id[i] ^ (k == 1 && i == 40));
      u_mst.wr_byte(CMD_WRITE_SP);
      u_mst.wr_byte(8'h03);
      u_mst.wr_byte(8'h96);
      chk("match_writes", n + (k == 0), wr_log.size());
    end
    chk("match_data", {3'h3, 3'h0, 8'h96}, wr_log[wr_log.size() - 1]);
    $display("t_match done");
  endtask : t_match

  initial begin
    rst_n = 1'b0;
    err_total = 0;
    compares = 0;
    repeat (3) @(negedge core_clk);
    rst_n = 1'b1;
    chk("dq_oe_n_rst", 1'b1, dq_oe_n);
    chk("sp_wr_rst", 1'b0, sp_wr);
    t_write_sp();
    t_read_id();
    t_search();
    t_bad_order();
    t_match();
    report_and_stop();
  end

  // the tests need about 0.74 ms; cut a hang well past that
  initial begin
    #1_500_000;
    err_total++;
    $display("Error watchdog expected done seen timeout");
    report_and_stop();
  end
endmodule : tb_single_wire_slave_rom_layer
`default_nettype wire
